// file: hw/sfmr_regs.svh
// Opcodes, phase lengths and reset values of the multi-line flash read front end
`ifndef SFMR_REGS_SVH
`define SFMR_REGS_SVH

// Command opcodes
`define SFMR_OP_QUAD_OUT     8'h6B
`define SFMR_OP_QUAD_IO      8'hEB
`define SFMR_OP_DUAL_OUT     8'h3B
`define SFMR_OP_DUAL_IO      8'hBB
`define SFMR_OP_SET_BURST    8'hC0
`define SFMR_OP_NIBBLE_BURST 8'h0C
`define SFMR_OP_SINGLE_BURST 8'hEC
`define SFMR_OP_ID_READ      8'h9F
`define SFMR_OP_QUAD_EXIT    8'hFF

// Mode byte upper nibble that keeps continuation mode
`define SFMR_MODE_CONTINUE   4'hA

// Phase lengths in serial clocks
`define SFMR_CMD_CLK_SINGLE  6'h08
`define SFMR_CMD_CLK_NIBBLE  6'h02
`define SFMR_ADDR_CLK_X1     6'h18
`define SFMR_ADDR_CLK_X2     6'h0C
`define SFMR_ADDR_CLK_X4     6'h06
`define SFMR_MODE_CLK_X2     6'h04
`define SFMR_MODE_CLK_X4     6'h02
`define SFMR_DUMMY_CLK_X1    6'h08
`define SFMR_DUMMY_CLK_QIO   6'h04
`define SFMR_DUMMY_CLK_BURST 6'h06

// Count value at which the first address byte of a continuation read is complete
`define SFMR_CONT_CHK_X4     6'h05
`define SFMR_CONT_CHK_X2     6'h09

// Lane groups left in a byte after its first group is driven
`define SFMR_LEFT_X1         3'h7
`define SFMR_LEFT_X2         3'h3
`define SFMR_LEFT_X4         3'h1

// Reset values and last identification index
`define SFMR_BURST_LEN_RST   2'h0
`define SFMR_ADDR_RST        24'h00_0000
`define SFMR_ID_LAST_INDEX   2'h2

`endif

// file: hw/sfmr_pkg.sv
// Types shared by the multi-line flash read front end
`default_nettype none

package sfmr_pkg;

  // Transaction phase
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_MODE   = 3'b011,
    ST_DUMMY  = 3'b100,
    ST_SETLEN = 3'b101,
    ST_DATA   = 3'b110,
    ST_IGNORE = 3'b111
  } sfmr_state_t;

  // Decoded command
  typedef enum logic [3:0] {
    CK_NONE     = 4'b0000,
    CK_QOUT     = 4'b0001,
    CK_QIO      = 4'b0010,
    CK_DOUT     = 4'b0011,
    CK_DIO      = 4'b0100,
    CK_BURSTSET = 4'b0101,
    CK_NBURST   = 4'b0110,
    CK_SBURST   = 4'b0111,
    CK_ID       = 4'b1000,
    CK_EXIT     = 4'b1001
  } sfmr_cmd_t;

  // Number of I/O lines in use
  typedef enum logic [1:0] {
    LN1 = 2'b00,
    LN2 = 2'b01,
    LN4 = 2'b10
  } sfmr_lanes_t;

endpackage : sfmr_pkg

`default_nettype wire

// file: hw/sfmr_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none

module sfmr_sync #(
  parameter int unsigned    WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Pin side and clock side
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

  // Two stages, reset to the idle pin level
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meta_q   <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sfmr_sync

`default_nettype wire

// file: hw/sfmr_top.sv
// Multi-line read command front end of a serial flash device
`timescale 1ns/100ps
`default_nettype none
`include "sfmr_regs.svh"

// Function
// - 6BH: single-line address, dummy, four-line data
// - Linear read increments address, wraps at top
// - EBH: four-line address, mode, two dummies
// - Mode nibble A: next read skips opcode
// - Other mode value: next transaction needs opcode
// - FFH leaves continuation mode
// - C0H plus one data cycle, both protocols
// - Burst codes 0-3 give 8-64 bytes, default 8
// - 0CH nibble protocol, address, three dummies, wrap
// - ECH address, three dummies, wrapped data
// - Wrap inside aligned burst-length window
// - Read-locked bytes return 00H in wrapped reads
// - Output data changes on serial clock fall
// - 3BH single-line address, dummy, two-line data
// - BBH two-line address and mode, no dummy
// - Dual mode nibble A: next read skips opcode
// - 9FH streams three identification bytes repeatedly
// - Command takes two or eight clocks
// - FFH in continuation only restores opcodes
module sfmr_top
  import sfmr_pkg::*;
#(
  parameter logic [7:0] ID_MAKER = 8'h5A,  // Arbitrary value
  parameter logic [7:0] ID_TYPE  = 8'hA5,  // Arbitrary value
  parameter logic [7:0] ID_CODE  = 8'h3C   // Arbitrary value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial pins from the host
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic [3:0]  serial_io_in,
  output logic      [3:0]  serial_io_out,
  output logic      [3:0]  serial_io_oe,
  // Array read port
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_locked,
  // Configuration from neighbouring logic
  input  wire logic        io_config_bit,
  input  wire logic        enter_nibble_wide,
  output logic             nibble_wide_protocol,
  output logic      [1:0]  burst_len
);

  // Synchronised pins
  logic [5:0]  sync_bus;            // Chip select, clock, four lines
  logic        cs_n_s;              // Chip select, clock domain
  logic        sck_s;               // Serial clock, clock domain
  logic [3:0]  io_s;                // I/O lines, clock domain
  logic        sck_p_q;             // Serial clock one cycle back
  logic        cs_p_q;              // Chip select one cycle back
  logic        sck_rise;            // Sampling edge
  logic        sck_fall;            // Output edge
  logic        cs_fall;             // Transaction start

  // Sequencer state
  sfmr_state_t st_q, st_d;          // Phase
  sfmr_cmd_t   kind_q, kind_d;      // Command in progress
  sfmr_cmd_t   cmd_kind;            // Decode of the received opcode
  sfmr_lanes_t inw_q, inw_d;        // Input lanes
  sfmr_lanes_t outw;                // Output lanes of the command
  logic [5:0]  cnt_q, cnt_d;        // Clocks left in the phase
  logic [23:0] rx_q, rx_d;          // Input shift register
  logic        last_clk;            // Final clock of a phase
  logic [7:0]  opcode;              // Received command byte

  // Mode and continuation state
  logic        cont_q;              // Continuation mode armed
  logic        cont_dual_q;         // Continuation is of the dual kind
  logic        chk_q;               // First address byte still unchecked
  logic [5:0]  chk_cnt;             // Count at which that byte completes
  logic        exit_hit;            // Exit byte seen in place of address
  logic        nibble_q;            // Nibble-wide protocol active
  logic [1:0]  blen_q;              // Burst length code

  // Address and output path
  logic [23:0] addr_q;              // Read pointer
  logic [23:0] addr_inc;            // Pointer plus one
  logic [23:0] addr_wrap;           // Pointer stepped inside the window
  logic [23:0] addr_nx;             // Pointer after this byte
  logic [5:0]  wrap_mask;           // Offset bits inside the window
  logic        is_wrap;             // Wrapped burst command
  logic [7:0]  id_byte;             // Identification byte at the pointer
  logic [7:0]  new_byte;            // Next byte to send
  logic [7:0]  out_src;             // Byte whose top lanes go out now
  logic [7:0]  out_sh_q;            // Remaining bits of current byte
  logic [7:0]  sh_nx;               // Remaining bits after this group
  logic [2:0]  out_left_q;          // Lane groups left in current byte
  logic [2:0]  left_nx;             // Lane groups left after this one
  logic [3:0]  out_pins;            // Next pin levels
  logic [3:0]  oe_pins;             // Next pin enables
  logic [3:0]  io_out_q;            // Driven pin levels
  logic [3:0]  io_oe_q;             // Driven pin enables

  // Pin synchroniser; chip select idles high
  sfmr_sync #(
    .WIDTH (6),
    .INIT  (6'h20)
  ) sfmr_sync_inst (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({chip_select_n, serial_clk, serial_io_in}),
    .sync_out (sync_bus)
  );

  assign cs_n_s = sync_bus[5];
  assign sck_s  = sync_bus[4];
  assign io_s   = sync_bus[3:0];

  // Edge detection on the synchronised pins
  assign sck_rise = sck_s & ~sck_p_q;
  assign sck_fall = ~sck_s & sck_p_q;
  assign cs_fall  = ~cs_n_s & cs_p_q;

  // Input shift by the lanes in use
  assign rx_d = (inw_q == LN1) ? {rx_q[22:0], io_s[0]} :
                (inw_q == LN2) ? {rx_q[21:0], io_s[1:0]} :
                                 {rx_q[19:0], io_s};
  assign opcode   = rx_d[7:0];
  assign last_clk = sck_rise && (cnt_q == 6'h01);

  // Opcode decode; quad reads need the configuration bit
  always_comb
  begin
    case (opcode)
      `SFMR_OP_QUAD_OUT:     cmd_kind = (!nibble_q && io_config_bit) ? CK_QOUT : CK_NONE;
      `SFMR_OP_QUAD_IO:      cmd_kind = (!nibble_q && io_config_bit) ? CK_QIO : CK_NONE;
      `SFMR_OP_DUAL_OUT:     cmd_kind = nibble_q ? CK_NONE : CK_DOUT;
      `SFMR_OP_DUAL_IO:      cmd_kind = nibble_q ? CK_NONE : CK_DIO;
      `SFMR_OP_SET_BURST:    cmd_kind = CK_BURSTSET;
      `SFMR_OP_NIBBLE_BURST: cmd_kind = nibble_q ? CK_NBURST : CK_NONE;
      `SFMR_OP_SINGLE_BURST: cmd_kind = nibble_q ? CK_NONE : CK_SBURST;
      `SFMR_OP_ID_READ:      cmd_kind = nibble_q ? CK_NONE : CK_ID;
      `SFMR_OP_QUAD_EXIT:    cmd_kind = CK_EXIT;
      default:               cmd_kind = CK_NONE;
    endcase
  end

  // Output lane count per command
  assign outw = (kind_q == CK_DOUT || kind_q == CK_DIO) ? LN2 :
                (kind_q == CK_ID) ? LN1 : LN4;

  // Exit byte in the first address slot of a continuation read
  assign chk_cnt  = cont_dual_q ? `SFMR_CONT_CHK_X2 : `SFMR_CONT_CHK_X4;
  assign exit_hit = sck_rise && (st_q == ST_ADDR) && chk_q && (cnt_q == chk_cnt)
                    && (rx_d[7:0] == `SFMR_OP_QUAD_EXIT);

  // Phase sequencer
  always_comb
  begin
    st_d   = st_q;
    kind_d = kind_q;
    cnt_d  = cnt_q;
    inw_d  = inw_q;
    if (cs_n_s)
    begin
      st_d = ST_IDLE;
    end
    else if (cs_fall)
    begin
      if (cont_q)
      begin
        // Opcode skipped, address straight away
        st_d   = ST_ADDR;
        kind_d = cont_dual_q ? CK_DIO : CK_QIO;
        inw_d  = cont_dual_q ? LN2 : LN4;
        cnt_d  = cont_dual_q ? `SFMR_ADDR_CLK_X2 : `SFMR_ADDR_CLK_X4;
      end
      else
      begin
        st_d   = ST_CMD;
        kind_d = CK_NONE;
        inw_d  = nibble_q ? LN4 : LN1;
        cnt_d  = nibble_q ? `SFMR_CMD_CLK_NIBBLE : `SFMR_CMD_CLK_SINGLE;
      end
    end
    else if (exit_hit)
    begin
      st_d = ST_IGNORE;
    end
    else if (sck_rise && st_q != ST_DATA && st_q != ST_IDLE && st_q != ST_IGNORE)
    begin
      cnt_d = cnt_q - 6'h01;
      if (last_clk)
      begin
        case (st_q)
          ST_CMD:
          begin
            kind_d = cmd_kind;
            case (cmd_kind)
              // Single-line address
              CK_QOUT, CK_DOUT:
              begin
                st_d  = ST_ADDR;
                inw_d = LN1;
                cnt_d = `SFMR_ADDR_CLK_X1;
              end
              // Four-line address
              CK_QIO, CK_NBURST, CK_SBURST:
              begin
                st_d  = ST_ADDR;
                inw_d = LN4;
                cnt_d = `SFMR_ADDR_CLK_X4;
              end
              // Two-line address
              CK_DIO:
              begin
                st_d  = ST_ADDR;
                inw_d = LN2;
                cnt_d = `SFMR_ADDR_CLK_X2;
              end
              // One data cycle in the current protocol
              CK_BURSTSET:
              begin
                st_d  = ST_SETLEN;
                cnt_d = nibble_q ? `SFMR_CMD_CLK_NIBBLE : `SFMR_CMD_CLK_SINGLE;
              end
              // Data right after the opcode
              CK_ID:
              begin
                st_d = ST_DATA;
              end
              default:
              begin
                st_d = ST_IGNORE;
              end
            endcase
          end
          ST_ADDR:
          begin
            case (kind_q)
              CK_QIO:
              begin
                st_d  = ST_MODE;
                cnt_d = `SFMR_MODE_CLK_X4;
              end
              CK_DIO:
              begin
                st_d  = ST_MODE;
                cnt_d = `SFMR_MODE_CLK_X2;
              end
              CK_NBURST, CK_SBURST:
              begin
                st_d  = ST_DUMMY;
                cnt_d = `SFMR_DUMMY_CLK_BURST;
              end
              default:
              begin
                st_d  = ST_DUMMY;
                cnt_d = `SFMR_DUMMY_CLK_X1;
              end
            endcase
          end
          ST_MODE:
          begin
            if (kind_q == CK_QIO)
            begin
              st_d  = ST_DUMMY;
              cnt_d = `SFMR_DUMMY_CLK_QIO;
            end
            else
            begin
              st_d = ST_DATA;
            end
          end
          ST_DUMMY:  st_d = ST_DATA;
          ST_SETLEN: st_d = ST_IGNORE;
          default:   st_d = st_q;
        endcase
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q    <= ST_IDLE;
      kind_q  <= CK_NONE;
      inw_q   <= LN1;
      cnt_q   <= 6'h00;
      rx_q    <= 24'h00_0000;
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      kind_q  <= kind_d;
      inw_q   <= inw_d;
      cnt_q   <= cnt_d;
      rx_q    <= sck_rise ? rx_d : rx_q;
      sck_p_q <= sck_s;
      cs_p_q  <= cs_n_s;
    end
  end

  // Continuation and protocol mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cont_q      <= 1'b0;
      cont_dual_q <= 1'b0;
      chk_q       <= 1'b0;
      nibble_q    <= 1'b0;
    end
    else if (exit_hit)
    begin
      cont_q <= 1'b0;
      chk_q  <= 1'b0;
    end
    else if (cs_fall)
    begin
      chk_q <= cont_q;
    end
    else if (last_clk && st_q == ST_MODE)
    begin
      cont_q      <= (rx_d[7:4] == `SFMR_MODE_CONTINUE);
      cont_dual_q <= (kind_q == CK_DIO);
    end
    else if (last_clk && st_q == ST_CMD && cmd_kind == CK_EXIT)
    begin
      nibble_q <= 1'b0;
    end
    else if (enter_nibble_wide && cs_n_s)
    begin
      nibble_q <= 1'b1;
    end
    else if (sck_rise && st_q == ST_ADDR && cnt_q == chk_cnt)
    begin
      chk_q <= 1'b0;
    end
  end

  // Burst length code, upper bits must be zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      blen_q <= `SFMR_BURST_LEN_RST;
    else if (last_clk && st_q == ST_SETLEN && rx_d[7:2] == 6'h00)
      blen_q <= rx_d[1:0];
  end

  // Address stepping
  assign wrap_mask = {blen_q == 2'h3, blen_q[1], blen_q != 2'h0, 3'h7};
  assign addr_inc  = addr_q + 24'h00_0001;
  assign addr_wrap = {addr_q[23:6], (addr_q[5:0] & ~wrap_mask) | (addr_inc[5:0] & wrap_mask)};
  assign is_wrap   = (kind_q == CK_NBURST) || (kind_q == CK_SBURST);
  assign addr_nx   = (kind_q == CK_ID) ? ((addr_q[1:0] == `SFMR_ID_LAST_INDEX) ? `SFMR_ADDR_RST : addr_inc) :
                     is_wrap ? addr_wrap : addr_inc;

  // Read pointer; identification reads index from zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      addr_q <= `SFMR_ADDR_RST;
    else if (last_clk && st_q == ST_CMD && cmd_kind == CK_ID)
      addr_q <= `SFMR_ADDR_RST;
    else if (last_clk && st_q == ST_ADDR)
      addr_q <= rx_d;
    else if (sck_fall && st_q == ST_DATA && out_left_q == 3'h0)
      addr_q <= addr_nx;
  end

  // Byte selection and lane mapping
  assign id_byte  = (addr_q[1:0] == 2'h0) ? ID_MAKER :
                    (addr_q[1:0] == 2'h1) ? ID_TYPE : ID_CODE;
  assign new_byte = (kind_q == CK_ID) ? id_byte :
                    (is_wrap && mem_locked) ? 8'h00 : mem_rdata;
  assign out_src  = (out_left_q == 3'h0) ? new_byte : out_sh_q;
  assign sh_nx    = (outw == LN1) ? {out_src[6:0], 1'b0} :
                    (outw == LN2) ? {out_src[5:0], 2'h0} : {out_src[3:0], 4'h0};
  assign left_nx  = (out_left_q != 3'h0) ? out_left_q - 3'h1 :
                    (outw == LN1) ? `SFMR_LEFT_X1 :
                    (outw == LN2) ? `SFMR_LEFT_X2 : `SFMR_LEFT_X4;
  assign out_pins = (outw == LN1) ? {2'h0, out_src[7], 1'b0} :
                    (outw == LN2) ? {2'h0, out_src[7:6]} : out_src[7:4];
  assign oe_pins  = (outw == LN1) ? 4'h2 : (outw == LN2) ? 4'h3 : 4'hF;

  // Output shifter, updated on the falling serial edge
  always_ff @(posedge core_clk)
  begin
    if (reset || cs_n_s)
    begin
      io_out_q   <= 4'h0;
      io_oe_q    <= 4'h0;
      out_sh_q   <= 8'h00;
      out_left_q <= 3'h0;
    end
    else if (sck_fall && st_q == ST_DATA)
    begin
      io_out_q   <= out_pins;
      io_oe_q    <= oe_pins;
      out_sh_q   <= sh_nx;
      out_left_q <= left_nx;
    end
  end

  // Outputs
  assign serial_io_out        = io_out_q;
  assign serial_io_oe         = io_oe_q;
  assign mem_addr             = addr_q;
  assign nibble_wide_protocol = nibble_q;
  assign burst_len            = blen_q;

endmodule : sfmr_top

`default_nettype wire

// file: tb/sfmr_checker.sv
// Pin-level concurrent checks of the flash read front end
`timescale 1ns/100ps
`default_nettype none

module sfmr_checker (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic [3:0]  serial_io_out,
  input  wire logic [3:0]  serial_io_oe,
  // Array side and settings
  input  wire logic [23:0] mem_addr,
  input  wire logic        nibble_wide_protocol,
  input  wire logic [1:0]  burst_len
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Frame edges and what must follow them
  sequence frame_start; $fell(chip_select_n); endsequence
  sequence frame_end; $rose(chip_select_n); endsequence
  sequence lines_free; ##[1:6] serial_io_oe == 4'h0; endsequence
  sequence lines_quiet; (serial_io_oe == 4'h0) [*8]; endsequence
  // Address steps while a lane group keeps driving
  sequence step_on(logic [3:0] lanes); $changed(mem_addr) && serial_io_oe == lanes && $past(serial_io_oe) == lanes;
  endsequence

  oe_legal_a: assert property (serial_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("Illegal output enable pattern");
  cs_release_a: assert property (frame_end |-> lines_free)
    else $error("Lines still driven after deselect");
  out_on_fall_a: assert property (($changed(serial_io_out) || $changed(serial_io_oe)) && !chip_select_n |-> !serial_clk)
    else $error("Output changed while serial clock high");
  reset_vals_a: assert property ($past(reset) |-> burst_len == 2'h0 && !nibble_wide_protocol && serial_io_oe == 4'h0)
    else $error("Wrong value after reset");
  dual_step_a: assert property (step_on(4'h3) |-> mem_addr == $past(mem_addr) + 24'h00_0001)
    else $error("Linear dual read skipped an address");
  quad_window_a: assert property (step_on(4'hF) |-> mem_addr == $past(mem_addr) + 24'h00_0001 || mem_addr[23:6] == $past(mem_addr[23:6]))
    else $error("Quad read address left its window");
  burst_idle_a: assert property ($changed(burst_len) |-> serial_io_oe == 4'h0 && $past(serial_io_oe) == 4'h0)
    else $error("Burst length changed during a read");
  quiet_start_a: assert property (frame_start |=> lines_quiet)
    else $error("Lines driven before a command could finish");
endmodule : sfmr_checker

`default_nettype wire

// file: tb/sfmr_host.sv
// Host controller model driving the serial pins
`timescale 1ns/100ps
`default_nettype none

module sfmr_host (
  // Clock
  input  wire logic       core_clk,
  // Serial pins
  output logic            chip_select_n,
  output logic            serial_clk,
  output logic [3:0]      serial_io_in,
  input  wire logic [3:0] serial_io_out,
  input  wire logic [3:0] serial_io_oe
);
  logic [3:0] host_drv_q;  // Host side line levels
  logic       oe_seen;     // Device drove a line in this frame

  // Wire level: device wins on lines it enables
  assign serial_io_in = (serial_io_oe & serial_io_out) | (~serial_io_oe & host_drv_q);

  initial
  begin
    chip_select_n = 1'b1;
    serial_clk    = 1'b0;
    host_drv_q    = 4'h0;
    oe_seen       = 1'b0;
  end

  // Open or close a frame; serial clock stays low outside frames
  task automatic frame(input logic open);
    @(posedge core_clk);
    chip_select_n <= ~open;
    oe_seen = 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : frame

  // One byte in groups of w lines, MSB first, 160 ns per serial clock
  task automatic xb(input int w, input logic drv, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int i = 0; i < 8 / w; i++)
    begin
      @(posedge core_clk);
      // Released lines toggle so a stale level never passes
      if (!drv)
        host_drv_q <= ~host_drv_q;
      else if (w == 1)
        host_drv_q <= {3'h0, sh[7]};
      else if (w == 2)
        host_drv_q <= {2'h0, sh[7:6]};
      else
        host_drv_q <= sh[7:4];
      sh = sh << w;
      repeat (7) @(posedge core_clk);
      serial_clk <= 1'b1;
      rx = (w == 1) ? {rx[6:0], serial_io_in[1]} : (w == 2) ? {rx[5:0], serial_io_in[1:0]} : {rx[3:0], serial_io_in};
      oe_seen = oe_seen | (|serial_io_oe);
      repeat (8) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
  endtask : xb
endmodule : sfmr_host

`default_nettype wire

// file: tb/sfmr_top_bench.sv
// Self-checking bench of the flash read front end
`timescale 1ns/100ps
`default_nettype none

module sfmr_top_bench;
  import sfmr_pkg::*;
  localparam logic [7:0] MK = 8'h5A;  // Arbitrary value, default identity of the block
  localparam logic [7:0] TY = 8'hA5;  // Arbitrary value, default identity of the block
  localparam logic [7:0] CD = 8'h3C;  // Arbitrary value, default identity of the block
  logic        core_clk, reset, io_config_bit, enter_nibble_wide;
  logic        chip_select_n, serial_clk, mem_locked, nibble_wide_protocol;
  logic [3:0]  serial_io_in, serial_io_out, serial_io_oe;
  logic [23:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic [1:0]  burst_len;
  int          mismatches, cmp_count;

  // Array model: pattern data, low byte zero is locked
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h69;
  endfunction : pat
  assign mem_rdata  = pat(mem_addr);
  assign mem_locked = (mem_addr[7:0] == 8'h00);

  sfmr_top sfmr_top_inst (
    .core_clk(core_clk), .reset(reset), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_io_in(serial_io_in), .serial_io_out(serial_io_out), .serial_io_oe(serial_io_oe),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_locked(mem_locked), .io_config_bit(io_config_bit),
    .enter_nibble_wide(enter_nibble_wide), .nibble_wide_protocol(nibble_wide_protocol), .burst_len(burst_len));
  sfmr_host sfmr_host_inst (.core_clk(core_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_io_in(serial_io_in), .serial_io_out(serial_io_out), .serial_io_oe(serial_io_oe));

  // Compare helpers and byte movers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic snd(input int w, input logic [7:0] b);
    logic [7:0] r;
    sfmr_host_inst.xb(w, 1'b1, b, r);
  endtask : snd
  task automatic adr(input int w, input logic [23:0] a);
    snd(w, a[23:16]);
    snd(w, a[15:8]);
    snd(w, a[7:0]);
  endtask : adr
  task automatic rcv(input int w, input logic [7:0] exp);
    logic [7:0] r;
    sfmr_host_inst.xb(w, 1'b0, 8'h00, r);
    chk(r, exp);
  endtask : rcv

  // Identification stream repeats after three bytes
  task automatic t_id();
    sfmr_host_inst.frame(1'b1);
    snd(1, 8'h9F);
    rcv(1, MK);
    rcv(1, TY);
    rcv(1, CD);
    rcv(1, MK);
    sfmr_host_inst.frame(1'b0);
  endtask : t_id

  // Quad output across the top of memory, then refused without config
  task automatic t_quad_out();
    for (int k = 1; k >= 0; k--)
    begin
      io_config_bit <= k[0];
      sfmr_host_inst.frame(1'b1);
      snd(1, 8'h6B);
      adr(1, 24'hFF_FFFE);
      snd(1, 8'h00);
      if (k == 1)
      begin
        rcv(4, pat(24'hFF_FFFE));
        rcv(4, pat(24'hFF_FFFF));
        rcv(4, pat(24'h00_0000));
      end
      else
      begin
        snd(4, 8'h00);
        chk({7'h00, sfmr_host_inst.oe_seen}, 8'h00);
      end
      sfmr_host_inst.frame(1'b0);
    end
    io_config_bit <= 1'b1;
  endtask : t_quad_out

  // Dual output linear read
  task automatic t_dual_out();
    sfmr_host_inst.frame(1'b1);
    snd(1, 8'h3B);
    adr(1, 24'h01_23FE);
    snd(1, 8'h00);
    for (int i = 0; i < 3; i++)
      rcv(2, pat(24'h01_23FE + 24'(i)));
    sfmr_host_inst.frame(1'b0);
  endtask : t_dual_out

  // Quad and dual I/O reads with continuation, then cancel
  task automatic t_cont();
    sfmr_host_inst.frame(1'b1);
    snd(1, 8'hEB);
    adr(4, 24'h00_3456);
    snd(4, 8'hA5);
    snd(4, 8'h00);
    snd(4, 8'h00);
    rcv(4, pat(24'h00_3456));
    rcv(4, pat(24'h00_3457));
    sfmr_host_inst.frame(1'b0);
    sfmr_host_inst.frame(1'b1);
    adr(4, 24'h00_ABCD);
    snd(4, 8'h50);
    snd(4, 8'h00);
    snd(4, 8'h00);
    rcv(4, pat(24'h00_ABCD));
    sfmr_host_inst.frame(1'b0);
    t_id();
    sfmr_host_inst.frame(1'b1);
    snd(1, 8'hBB);
    adr(2, 24'h02_0777);
    snd(2, 8'hAF);
    rcv(2, pat(24'h02_0777));
    rcv(2, pat(24'h02_0778));
    sfmr_host_inst.frame(1'b0);
    sfmr_host_inst.frame(1'b1);
    adr(2, 24'h00_0912);
    snd(2, 8'hA0);
    rcv(2, pat(24'h00_0912));
    sfmr_host_inst.frame(1'b0);
    sfmr_host_inst.frame(1'b1);
    snd(2, 8'hFF);
    snd(2, 8'h00);
    sfmr_host_inst.frame(1'b0);
    t_id();
  endtask : t_cont

  // Every burst code, then wrapped reads in both protocols
  task automatic t_burst();
    for (int c = 3; c >= 0; c--)
    begin
      sfmr_host_inst.frame(1'b1);
      snd(1, 8'hC0);
      snd(1, 8'(c));
      sfmr_host_inst.frame(1'b0);
      chk({6'h00, burst_len}, 8'(c));
    end
    sfmr_host_inst.frame(1'b1);
    snd(1, 8'hEC);
    adr(4, 24'h00_0106);
    repeat (3) snd(4, 8'h00);
    rcv(4, pat(24'h00_0106));
    rcv(4, pat(24'h00_0107));
    rcv(4, 8'h00);
    rcv(4, pat(24'h00_0101));
    sfmr_host_inst.frame(1'b0);
    enter_nibble_wide <= 1'b1;
    @(posedge core_clk);
    enter_nibble_wide <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({7'h00, nibble_wide_protocol}, 8'h01);
    sfmr_host_inst.frame(1'b1);
    snd(4, 8'hC0);
    snd(4, 8'h01);
    sfmr_host_inst.frame(1'b0);
    chk({6'h00, burst_len}, 8'h01);
    sfmr_host_inst.frame(1'b1);
    snd(4, 8'h0C);
    adr(4, 24'h00_021E);
    repeat (3) snd(4, 8'h00);
    rcv(4, pat(24'h00_021E));
    rcv(4, pat(24'h00_021F));
    rcv(4, pat(24'h00_0210));
    sfmr_host_inst.frame(1'b0);
    sfmr_host_inst.frame(1'b1);
    snd(4, 8'hFF);
    sfmr_host_inst.frame(1'b0);
    chk({7'h00, nibble_wide_protocol}, 8'h00);
  endtask : t_burst

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    reset = 1'b1;
    io_config_bit = 1'b1;
    enter_nibble_wide = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({6'h00, burst_len}, 8'h00);
    t_id();
    t_quad_out();
    t_dual_out();
    t_cont();
    t_burst();
    give_verdict();
  end
endmodule : sfmr_top_bench

bind sfmr_top sfmr_checker sfmr_checker_inst (
  .core_clk(core_clk), .reset(reset), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
  .serial_io_out(serial_io_out), .serial_io_oe(serial_io_oe), .mem_addr(mem_addr),
  .nibble_wide_protocol(nibble_wide_protocol), .burst_len(burst_len));

`default_nettype wire
